/* hdl/stack_limit_checker.sv */
`timescale 1ns/1ps
// Functional notes
// R1: stack pointer holds next free word; stack grows upward in address.
// R2: pop decrements then reads; push writes then increments.
// R3: call pushes PC with upper byte zero-extended, top bit clear.
// R4: exception pushes PC with status low byte joined to PC upper byte.
// R5: bit 0 of the stack limit always reads zero.
// R6: stack limit has no reset value; undefined until software loads it. Code reads stack_limit_o as zero until the first limit write.
// R7: every stack-pointer effective address is compared with the stack limit. Code skips the compare until the limit has first been written.
// R8: push at pointer equal to limit is fine; the next push traps overflow.
// R9: underflow trap when stack address falls below 0x0800.
// R10: software must not follow a limit write with stack-pointer indirect read.
// R11: enabled boot secure ram only reachable from boot flash code.
// R12: enabled segment secure ram only reachable from secure flash code.
// R13: traps are one-cycle pulses in the cycle the stack address forms.
module stack_limit_checker
  import stack_guard_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stack requests from the address generator
  input wire stack_req_t req_i,
  output logic req_ready_o,
  input wire logic [23:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  // other stack-pointer based effective addresses
  input wire sp_ea_t sp_ea_i,
  // working register writes to pointer and limit
  input wire logic sp_wr_i,
  input wire logic [15:0] sp_wdata_i,
  input wire logic limit_wr_i,
  input wire logic [15:0] limit_wdata_i,
  // data memory side
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  // state views
  output logic [15:0] stack_pointer_o,
  output logic [15:0] stack_limit_o,
  // traps to exception logic
  output logic overflow_trap_o,
  output logic underflow_trap_o,
  // secure ram gating
  input wire seg_cfg_t boot_secure_ram_i,
  input wire seg_cfg_t segment_secure_ram_i,
  input wire logic ram_access_i,
  input wire logic [15:0] ram_addr_i,
  output logic ram_grant_o,
  output logic ram_block_o
);

  // ==========================================================
  // state
  logic [15:0] stack_pointer_reg;
  logic [15:0] stack_limit_reg;
  logic limit_loaded_reg;
  logic [15:0] pc_hi_word_reg;
  push_state_t state_reg;
  logic mem_we_reg;
  logic mem_re_reg;
  logic [15:0] mem_addr_reg;
  logic [15:0] mem_wdata_reg;

  logic accept;
  logic gen_valid;
  logic gen_push;
  logic [15:0] gen_addr;
  logic [15:0] gen_wdata;
  logic [15:0] pc_hi_next;
  logic limit_over;
  logic below_sfr;
  logic boot_hit;
  logic boot_block;
  logic sec_hit;
  logic sec_block;

  assign req_ready_o = (state_reg == ST_IDLE);
  assign accept = req_i.valid && req_ready_o;

  // ==========================================================
  // address generation
  always_comb begin
    gen_valid = 1'b0;
    gen_push = 1'b0;
    gen_addr = stack_pointer_reg;
    gen_wdata = 16'h0000;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          gen_valid = 1'b1;
          case (req_i.op)
            OP_POP: begin
              gen_addr = stack_pointer_reg - WORD_STEP; // [R2]
            end
            OP_PUSH: begin
              gen_push = 1'b1;
              gen_wdata = req_i.data;
            end
            default: begin
              // low pc word goes first, upper word next cycle
              gen_push = 1'b1;
              gen_wdata = pc_i[15:0];
            end
          endcase
        end
      end
      ST_PC_HI: begin
        gen_valid = 1'b1;
        gen_push = 1'b1;
        gen_wdata = pc_hi_word_reg;
      end
      default: begin
        gen_valid = 1'b0;
      end
    endcase
  end

  // upper pc word formats
  always_comb begin
    if (req_i.op == OP_EXC_PC) begin
      pc_hi_next = {status_low_byte_i, 1'b0, pc_i[22:16]}; // [R4]
    end else begin
      pc_hi_next = {ZERO_BYTE, 1'b0, pc_i[22:16]}; // [R3]
    end
  end

  // ==========================================================
  // limit and underflow checks
  // both generated push/pop addresses and other stack-pointer modes are checked
  assign limit_over = limit_loaded_reg &&
    ((gen_valid && gen_addr > stack_limit_reg) ||
     (sp_ea_i.valid && sp_ea_i.addr > stack_limit_reg)); // [R7] [R8]
  assign below_sfr = (gen_valid && gen_addr < SFR_SPACE_END) ||
    (sp_ea_i.valid && sp_ea_i.addr < SFR_SPACE_END); // [R9]
  assign overflow_trap_o = limit_over; // [R13]
  assign underflow_trap_o = below_sfr; // [R13]

  // ==========================================================
  // sequencing of pc pushes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (accept && (req_i.op == OP_CALL_PC || req_i.op == OP_EXC_PC)) begin
      state_reg <= ST_PC_HI;
    end else begin
      state_reg <= ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_hi_word_reg <= 16'h0000;
    end else if (accept) begin
      pc_hi_word_reg <= pc_hi_next;
    end
  end

  // ==========================================================
  // stack pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_pointer_reg <= SP_RESET;
    end else if (gen_valid && gen_push) begin
      stack_pointer_reg <= stack_pointer_reg + WORD_STEP; // [R1] [R2]
    end else if (gen_valid) begin
      stack_pointer_reg <= gen_addr; // [R2]
    end else if (sp_wr_i) begin
      stack_pointer_reg <= {sp_wdata_i[15:1], 1'b0};
    end
  end
  assign stack_pointer_o = stack_pointer_reg;

  // ==========================================================
  // stack limit: deliberately left without reset
  always_ff @(posedge clk_i) begin
    if (limit_wr_i) begin
      stack_limit_reg <= {limit_wdata_i[15:1], 1'b0}; // [R5] [R6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_loaded_reg <= 1'b0;
    end else if (limit_wr_i) begin
      limit_loaded_reg <= 1'b1;
    end
  end
  // reads zero until loaded so the port is never unknown
  assign stack_limit_o = limit_loaded_reg ? stack_limit_reg : 16'h0000; // [R6]

  // ==========================================================
  // memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 16'h0000;
    end else begin
      mem_we_reg <= gen_valid && gen_push;
      mem_re_reg <= gen_valid && !gen_push;
      if (gen_valid) begin
        mem_addr_reg <= gen_addr;
        mem_wdata_reg <= gen_wdata;
      end
    end
  end
  assign mem_we_o = mem_we_reg;
  assign mem_re_o = mem_re_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;

  // ==========================================================
  // secure ram segments
  ram_segment_guard u_boot_guard (
    .cfg_i(boot_secure_ram_i),
    .access_valid_i(ram_access_i),
    .addr_i(ram_addr_i),
    .exec_pc_i(pc_i),
    .hit_o(boot_hit),
    .block_o(boot_block)
  ); // [R11]

  ram_segment_guard u_sec_guard (
    .cfg_i(segment_secure_ram_i),
    .access_valid_i(ram_access_i),
    .addr_i(ram_addr_i),
    .exec_pc_i(pc_i),
    .hit_o(sec_hit),
    .block_o(sec_block)
  ); // [R12]

  assign ram_block_o = boot_block || sec_block; // [R11] [R12]
  assign ram_grant_o = ram_access_i && !ram_block_o;

  // ==========================================================
  // checks
  // armed once a push lands on the limit; any pointer move back disarms
  logic past_limit_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      past_limit_reg <= 1'b0;
    end else if (limit_wr_i || (gen_valid && !gen_push) || (!gen_valid && sp_wr_i)) begin
      past_limit_reg <= 1'b0;
    end else if (gen_valid && gen_push && limit_loaded_reg && gen_addr == stack_limit_reg) begin
      past_limit_reg <= 1'b1;
    end
  end

  sequence s_push_at_limit;
    gen_valid && gen_push && limit_loaded_reg && gen_addr == stack_limit_reg &&
      !sp_ea_i.valid;
  endsequence

  sequence s_next_push;
    gen_valid && gen_push && !sp_wr_i;
  endsequence

  a_push_steps_up: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_valid && gen_push |=> stack_pointer_reg == $past(stack_pointer_reg) + WORD_STEP
  ) else $error("push did not advance stack pointer by one word"); // [R1]

  a_push_then_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_valid && gen_push |=> mem_we_o && mem_addr_o == $past(stack_pointer_reg)
  ) else $error("push wrote somewhere other than the old pointer"); // [R2]

  a_pop_dec_read: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_i.op == OP_POP |=> mem_re_o && mem_addr_o == stack_pointer_reg
  ) else $error("pop did not read at the decremented pointer"); // [R2]

  a_call_msb_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_i.op == OP_CALL_PC |=> ##1 mem_we_o && mem_wdata_o[15:7] == 9'h000
  ) else $error("call pushed pc upper word with high bits set"); // [R3]

  a_exc_status_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_i.op == OP_EXC_PC |=> ##1 mem_wdata_o[15:8] == $past(status_low_byte_i, 2)
  ) else $error("exception push lost status low byte"); // [R4]

  a_limit_bit_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    stack_limit_o[0] == 1'b0
  ) else $error("stack limit bit 0 not zero"); // [R5]

  a_equal_no_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    s_push_at_limit |-> !overflow_trap_o
  ) else $error("push at the limit raised overflow"); // [R8]

  a_next_push_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    past_limit_reg ##0 s_next_push |-> overflow_trap_o
  ) else $error("push past the limit did not trap"); // [R8]

  a_underflow_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_valid && gen_addr < SFR_SPACE_END |-> underflow_trap_o
  ) else $error("stack address below sfr space not trapped"); // [R9]

  a_trap_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow_trap_o |-> gen_valid || sp_ea_i.valid
  ) else $error("overflow trap without a stack address"); // [R13]

  a_boot_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_hit && !(pc_i >= boot_secure_ram_i.code_lo && pc_i <= boot_secure_ram_i.code_hi)
      |-> ram_block_o && !ram_grant_o
  ) else $error("boot secure ram reached from foreign code"); // [R11]

  a_secure_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    sec_hit && !(pc_i >= segment_secure_ram_i.code_lo && pc_i <= segment_secure_ram_i.code_hi)
      |-> ram_block_o && !ram_grant_o
  ) else $error("segment secure ram reached from foreign code"); // [R12]

endmodule

/* hdl/stack_guard_pkg.sv */
package stack_guard_pkg;

  // ==========================================================
  // widths and fixed addresses
  localparam int DATA_W = 16;
  localparam int PC_W = 24;
  localparam logic [15:0] SFR_SPACE_END = 16'h0800;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // stack request kinds
  typedef enum logic [1:0] {
    OP_PUSH = 2'b00,
    OP_POP = 2'b01,
    OP_CALL_PC = 2'b10,
    OP_EXC_PC = 2'b11
  } stack_op_t;

  typedef struct packed {
    logic valid;
    stack_op_t op;
    logic [15:0] data;
  } stack_req_t;

  // effective address formed from the stack pointer by other addressing modes
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } sp_ea_t;

  // one secure ram segment and the code region allowed to reach it
  typedef struct packed {
    logic enable;
    logic [15:0] ram_lo;
    logic [15:0] ram_hi;
    logic [23:0] code_lo;
    logic [23:0] code_hi;
  } seg_cfg_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PC_HI = 1'b1
  } push_state_t;

endpackage

/* hdl/ram_segment_guard.sv */
`timescale 1ns/1ps
module ram_segment_guard
  import stack_guard_pkg::*;
(
  // segment setup
  input wire seg_cfg_t cfg_i,
  // data access under test
  input wire logic access_valid_i,
  input wire logic [15:0] addr_i,
  input wire logic [23:0] exec_pc_i,
  // verdict
  output logic hit_o,
  output logic block_o
);

  logic in_ram;
  logic from_code;

  assign in_ram = (addr_i >= cfg_i.ram_lo) && (addr_i <= cfg_i.ram_hi);
  assign from_code = (exec_pc_i >= cfg_i.code_lo) && (exec_pc_i <= cfg_i.code_hi);
  assign hit_o = cfg_i.enable && access_valid_i && in_ram;
  // only code running in the owning flash segment may touch the segment
  assign block_o = hit_o && !from_code;

endmodule

/* sim/trap_sink.sv */
`timescale 1ns/1ps
module trap_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // trap pulses from the checker
  input wire logic overflow_trap_i,
  input wire logic underflow_trap_i,
  // event counts
  output logic [7:0] ovf_count_o,
  output logic [7:0] unf_count_o
);
  // ==========================================================
  // exception side: one count per pulse cycle, so a stretched pulse shows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_count_o <= 8'h00;
      unf_count_o <= 8'h00;
    end else begin
      ovf_count_o <= ovf_count_o + {7'h00, overflow_trap_i};
      unf_count_o <= unf_count_o + {7'h00, underflow_trap_i};
    end
  end
endmodule

/* sim/stack_limit_checker_tb.sv */
`timescale 1ns/1ps
module stack_limit_checker_tb;
  import stack_guard_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  stack_req_t req = '0;
  sp_ea_t ea = '0;
  seg_cfg_t boot_cfg = '0;
  seg_cfg_t seg_cfg = '0;
  logic [23:0] pc = 24'h000000;
  logic [7:0] status_low = 8'h00;
  logic sp_wr = 1'b0;
  logic lim_wr = 1'b0;
  logic ram_acc = 1'b0;
  logic [15:0] sp_wdata = 16'h0000;
  logic [15:0] lim_wdata = 16'h0000;
  logic [15:0] ram_addr = 16'h0000;
  logic ready, mem_we, mem_re, ovf, unf, grant, block;
  logic [15:0] mem_addr, mem_wdata, sp, lim;
  logic [7:0] ovf_cnt, unf_cnt;
  int miscompares = 0;
  int checks = 0;

  always #2.5 clk_i = ~clk_i;

  stack_limit_checker dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .req_ready_o(ready), .pc_i(pc),
    .status_low_byte_i(status_low), .sp_ea_i(ea), .sp_wr_i(sp_wr), .sp_wdata_i(sp_wdata),
    .limit_wr_i(lim_wr), .limit_wdata_i(lim_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .stack_pointer_o(sp),
    .stack_limit_o(lim), .overflow_trap_o(ovf), .underflow_trap_o(unf),
    .boot_secure_ram_i(boot_cfg), .segment_secure_ram_i(seg_cfg), .ram_access_i(ram_acc),
    .ram_addr_i(ram_addr), .ram_grant_o(grant), .ram_block_o(block));

  trap_sink partner (
    .clk_i(clk_i), .rst_i(rst_i), .overflow_trap_i(ovf), .underflow_trap_i(unf),
    .ovf_count_o(ovf_cnt), .unf_count_o(unf_cnt));

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  // trap outputs are judged before the taking edge, then must drop after it
  task automatic stack_op(input stack_op_t op, input logic [15:0] d, input logic eo, input logic eu);
    req = '{valid: 1'b1, op: op, data: d};
    #1;
    chk("ready", 16'h0001, {15'h0, ready});
    chk("overflow", {15'h0, eo}, {15'h0, ovf});
    chk("underflow", {15'h0, eu}, {15'h0, unf});
    tick();
    req = '0;
    #1;
    chk("overflow pulse", 16'h0000, {15'h0, ovf});
    chk("underflow pulse", 16'h0000, {15'h0, unf});
  endtask

  task automatic ea_probe(input logic [15:0] a, input logic eo);
    ea = '{valid: 1'b1, addr: a};
    #1;
    chk("ea overflow", {15'h0, eo}, {15'h0, ovf});
    tick();
    ea = '0;
  endtask

  task automatic sp_set(input logic [15:0] v);
    sp_wr = 1'b1;
    sp_wdata = v;
    tick();
    sp_wr = 1'b0;
  endtask

  task automatic lim_set(input logic [15:0] v);
    lim_wr = 1'b1;
    lim_wdata = v;
    tick();
    lim_wr = 1'b0;
    tick(); // no pointer access right after a limit write
  endtask

  task automatic mem_chk(input logic we, input logic re, input logic [15:0] a, input logic [15:0] d);
    chk("mem_we", {15'h0, we}, {15'h0, mem_we});
    chk("mem_re", {15'h0, re}, {15'h0, mem_re});
    chk("mem_addr", a, mem_addr);
    if (we) chk("mem_wdata", d, mem_wdata);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_push_pop();
    chk("sp reset", 16'h0800, sp);
    chk("limit unloaded", 16'h0000, lim);
    stack_op(OP_PUSH, 16'h1234, 1'b0, 1'b0);
    mem_chk(1'b1, 1'b0, 16'h0800, 16'h1234);
    stack_op(OP_PUSH, 16'h5678, 1'b0, 1'b0);
    mem_chk(1'b1, 1'b0, 16'h0802, 16'h5678);
    chk("sp after pushes", 16'h0804, sp);
    stack_op(OP_POP, 16'h0000, 1'b0, 1'b0);
    mem_chk(1'b0, 1'b1, 16'h0802, 16'h0000);
    stack_op(OP_POP, 16'h0000, 1'b0, 1'b0);
    mem_chk(1'b0, 1'b1, 16'h0800, 16'h0000);
    chk("sp after pops", 16'h0800, sp);
    $display("test push_pop done");
  endtask

  task automatic t_limit();
    lim_set(16'h0805);
    chk("limit bit0", 16'h0804, lim);
    stack_op(OP_PUSH, 16'h0001, 1'b0, 1'b0);
    stack_op(OP_PUSH, 16'h0002, 1'b0, 1'b0);
    stack_op(OP_PUSH, 16'h0003, 1'b0, 1'b0);
    stack_op(OP_PUSH, 16'h0004, 1'b1, 1'b0);
    ea_probe(16'h0806, 1'b1);
    ea_probe(16'h0804, 1'b0);
    sp_set(16'h0801);
    chk("sp write bit0", 16'h0800, sp);
    lim_set(16'hfffe);
    $display("test limit done");
  endtask

  task automatic t_pc_push();
    pc = 24'hfedcba;
    stack_op(OP_CALL_PC, 16'h0000, 1'b0, 1'b0);
    chk("ready gap", 16'h0000, {15'h0, ready});
    mem_chk(1'b1, 1'b0, 16'h0800, 16'hdcba);
    tick();
    mem_chk(1'b1, 1'b0, 16'h0802, 16'h007e);
    status_low = 8'ha5;
    pc = 24'hff1357;
    stack_op(OP_EXC_PC, 16'h0000, 1'b0, 1'b0);
    mem_chk(1'b1, 1'b0, 16'h0804, 16'h1357);
    tick();
    mem_chk(1'b1, 1'b0, 16'h0806, 16'ha57f);
    chk("sp after pc pushes", 16'h0808, sp);
    sp_set(16'h0800);
    $display("test pc_push done");
  endtask

  task automatic t_underflow();
    stack_op(OP_POP, 16'h0000, 1'b0, 1'b1);
    sp_set(16'h07fe);
    stack_op(OP_PUSH, 16'h0009, 1'b0, 1'b1);
    sp_set(16'h0800);
    chk("overflow events", 16'h0002, {8'h00, ovf_cnt});
    chk("underflow events", 16'h0002, {8'h00, unf_cnt});
    $display("test underflow done");
  endtask

  task automatic t_secure();
    logic [15:0] a [6] = '{16'h1000, 16'h10ff, 16'h2000, 16'h20ff, 16'h3000, 16'h1000};
    logic [23:0] p [6] = '{24'h000100, 24'h001800, 24'h001800, 24'h000100, 24'h000100,
                           24'h001800};
    logic b [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    boot_cfg = '{1'b1, 16'h1000, 16'h10ff, 24'h000000, 24'h0003ff};
    seg_cfg = '{1'b1, 16'h2000, 16'h20ff, 24'h001000, 24'h001fff};
    ram_acc = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) boot_cfg.enable = 1'b0;
      ram_addr = a[i];
      pc = p[i];
      tick();
      chk("ram block", {15'h0, b[i]}, {15'h0, block});
      chk("ram grant", {15'h0, !b[i]}, {15'h0, grant});
    end
    ram_acc = 1'b0;
    $display("test secure done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_push_pop();
    t_limit();
    t_pc_push();
    t_underflow();
    t_secure();
    tally_and_finish();
  end

  initial begin
    #5000;
    miscompares++;
    tally_and_finish();
  end
endmodule
